// >>> pkg/ocd_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 50 MHz clock, 10 ms detection time base
// Notes: Times in registers are in units of the 10 ms time base
`ifndef OCD_DEFINES_SVH
`define OCD_DEFINES_SVH
// ==========================================================
// Timing
`define OCD_CLK_NS 20
`define OCD_TICK_NS 10000000
`define OCD_TICK_CYCLES (`OCD_TICK_NS / `OCD_CLK_NS)
`define OCD_RESP_NS 100000000
`define OCD_RESP_TICKS (`OCD_RESP_NS / `OCD_TICK_NS)
`define OCD_ZC_MIN_NS 100000000
`define OCD_ZC_MIN_TICKS (`OCD_ZC_MIN_NS / `OCD_TICK_NS)
// ==========================================================
// Register byte offsets
`define OCD_OFS_OC_LEVEL 8'h00
`define OCD_OFS_OC_DELAY 8'h04
`define OCD_OFS_ZC_LEVEL 8'h08
`define OCD_OFS_ZC_TIME 8'h0c
`define OCD_OFS_OC_RETAIN 8'h10
`define OCD_OFS_OC_ACTION 8'h14
`define OCD_OFS_TERM_A 8'h18
`define OCD_OFS_TERM_B 8'h1c
`define OCD_OFS_STATUS 8'h20
`define OCD_OFS_IRQ_STAT 8'h24
`define OCD_OFS_IRQ_MASK 8'h28
`define OCD_OFS_CTRL 8'h2c
// ==========================================================
// Reset values
`define OCD_RST_OC_LEVEL 8'h96
`define OCD_RST_OC_DELAY 14'h0000
`define OCD_RST_ZC_LEVEL 8'h05
`define OCD_RST_ZC_TIME 14'h0032
`define OCD_RST_OC_RETAIN 14'h000a
`define OCD_RST_TERM 8'h00
// ==========================================================
// Codes and fields
`define OCD_RETAIN_HOLD 14'h270f
`define OCD_CODE_OC_POS 8'h0c
`define OCD_CODE_OC_NEG 8'h70
`define OCD_CODE_ZC_POS 8'h0d
`define OCD_CODE_ZC_NEG 8'h71
`define OCD_FAULT_CODE 8'h01
`define OCD_BIT_OC 0
`define OCD_BIT_ZC 1
`define OCD_BIT_FAULT 2
`define OCD_BIT_ACTIVE 3
`define OCD_FAULT_CODE_LSB 8
`endif

// >>> pkg/ocd_pkg.sv
// Purpose: Types of the output current detector
// Assumes: Constants come from ocd_defines.svh
// Notes: None
package ocd_pkg;
    typedef logic [7:0] ocd_pct_t;
    typedef logic [13:0] ocd_time_t;
    // Overcurrent flag holding modes
    typedef enum logic [1:0] {OC_OFF, OC_TIMED, OC_TO_START, OC_TO_RESET} ocd_oc_st_t;
endpackage

// >>> hw/ocd_top.sv
// Purpose: Output current detector with overcurrent and zero-current flags
// Assumes: Current sample in percent of rated current, synchronous to aclk
// Notes: AXI4-Lite register slave, one level interrupt output
// Functional notes
// - Compare current with overcurrent level, default 150%
// - Overcurrent flag after level exceeded past delay
// - Overcurrent flag held for retention time
// - Hold code keeps flag until next start
// - Action one trips and records fault
// - After trip, hold code keeps flag till reset
// - Action change applies only while flag off
// - Overcurrent drives terminal on codes 12/112
// - Compare current with zero level, default 5%
// - Zero flag after current low past time
// - Zero flag held about 0.1 s minimum
// - Zero flag drives terminal on codes 13/113
// - Zero level of zero disables detection
// - Detection stays active during auto-tuning
// - Flags respond with about 0.1 s latency
`timescale 1ns/10ps
`include "ocd_defines.svh"
module ocd_top #(
    parameter int unsigned TICK_CYCLES = `OCD_TICK_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Drive state
    input wire ocd_pkg::ocd_pct_t current_pct,
    input wire logic running,
    input wire logic tuning,
    input wire logic start_cmd,
    // Outputs to equipment and system
    output logic terminal_a,
    output logic terminal_b,
    output logic trip,
    output logic irq
);
    import ocd_pkg::*;

    // ==========================================================
    // Registers
    ocd_pct_t oc_level_q, oc_level_d; // Overcurrent level, percent
    ocd_time_t oc_delay_q, oc_delay_d; // Overcurrent delay, ticks
    ocd_pct_t zc_level_q, zc_level_d; // Zero-current level, percent
    ocd_time_t zc_time_q, zc_time_d; // Zero-current time, ticks
    ocd_time_t oc_retain_q, oc_retain_d; // Retention, ticks or hold code
    logic action_q, action_d; // Written action selector
    logic [7:0] term_a_q, term_a_d; // Function code, terminal A
    logic [7:0] term_b_q, term_b_d; // Function code, terminal B
    logic [2:0] irq_stat_q, irq_stat_d; // Sticky events
    logic [2:0] irq_mask_q, irq_mask_d; // Event enables
    // Bus handshake state
    logic aw_have_q, aw_have_d;
    logic w_have_q, w_have_d;
    logic [7:0] waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    // Detection state
    logic [19:0] tick_cnt_q, tick_cnt_d; // Time base divider
    logic [3:0] resp_cnt_q, resp_cnt_d; // Sample period, in ticks
    ocd_pct_t samp_q, samp_d; // Current seen by the detectors
    logic samp_act_q, samp_act_d; // Activity seen by the detectors
    ocd_time_t oc_cnt_q, oc_cnt_d; // Time above level
    ocd_time_t oc_ret_q, oc_ret_d; // Retention remaining
    ocd_oc_st_t oc_st_q, oc_st_d; // Overcurrent flag mode
    logic act_eff_q, act_eff_d; // Action selector in force
    logic fault_q, fault_d; // Recorded trip
    ocd_time_t zc_cnt_q, zc_cnt_d; // Time below level
    logic [3:0] zc_min_q, zc_min_d; // Minimum hold remaining
    logic zc_flag_q, zc_flag_d;
    logic term_a_o_q, term_a_o_d;
    logic term_b_o_q, term_b_o_d;

    // Combinational helpers
    logic tick;
    logic wr_fire;
    logic rd_fire;
    logic fault_clr;
    logic oc_flag;
    logic active;
    logic above;
    logic below;
    logic [2:0] events;
    logic [2:0] oc_ev; // Events of the overcurrent detector
    logic zc_rise; // Zero-current flag turned on

    // ==========================================================
    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Terminal level for one function code
    function automatic logic term_out(input logic [7:0] code,
        input logic ocf, input logic zcf);
        logic r;
        r = 1'b0;
        if (code == `OCD_CODE_OC_POS)
        begin
            r = ocf;
        end
        else if (code == `OCD_CODE_OC_NEG)
        begin
            r = !ocf;
        end
        else if (code == `OCD_CODE_ZC_POS)
        begin
            r = zcf;
        end
        else if (code == `OCD_CODE_ZC_NEG)
        begin
            r = !zcf;
        end
        return r;
    endfunction

    // ==========================================================
    // Bus slave
    // Write address and data are taken in either order, then one response
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign rd_fire = s_axi_arvalid && !rvalid_q;
    assign oc_flag = (oc_st_q != OC_OFF);

    // Write path, register file and read path
    always_comb
    begin
        logic [31:0] m;
        logic hit;
        m = merge(32'h0000_0000, wdata_q, wstrb_q);
        hit = 1'b1;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        oc_level_d = oc_level_q;
        oc_delay_d = oc_delay_q;
        zc_level_d = zc_level_q;
        zc_time_d = zc_time_q;
        oc_retain_d = oc_retain_q;
        action_d = action_q;
        term_a_d = term_a_q;
        term_b_d = term_b_q;
        irq_mask_d = irq_mask_q;
        fault_clr = 1'b0;
        // Events set their bit even in the cycle software clears it
        irq_stat_d = irq_stat_q | events;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_d = 1'b1;
            waddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            // Partial strobes merge into the stored value
            unique case (waddr_q)
                `OCD_OFS_OC_LEVEL: oc_level_d = 8'(merge({24'h0, oc_level_q}, wdata_q, wstrb_q));
                `OCD_OFS_OC_DELAY: oc_delay_d = 14'(merge({18'h0, oc_delay_q}, wdata_q, wstrb_q));
                `OCD_OFS_ZC_LEVEL: zc_level_d = 8'(merge({24'h0, zc_level_q}, wdata_q, wstrb_q));
                `OCD_OFS_ZC_TIME: zc_time_d = 14'(merge({18'h0, zc_time_q}, wdata_q, wstrb_q));
                `OCD_OFS_OC_RETAIN: oc_retain_d =
                    14'(merge({18'h0, oc_retain_q}, wdata_q, wstrb_q));
                `OCD_OFS_OC_ACTION: action_d = wstrb_q[0] ? wdata_q[0] : action_q;
                `OCD_OFS_TERM_A: term_a_d = wstrb_q[0] ? wdata_q[7:0] : term_a_q;
                `OCD_OFS_TERM_B: term_b_d = wstrb_q[0] ? wdata_q[7:0] : term_b_q;
                `OCD_OFS_STATUS: hit = 1'b1; // Read-only, write ignored
                `OCD_OFS_IRQ_STAT: irq_stat_d = (irq_stat_q & ~m[2:0]) | events;
                `OCD_OFS_IRQ_MASK: irq_mask_d = wstrb_q[0] ? wdata_q[2:0] : irq_mask_q;
                `OCD_OFS_CTRL: fault_clr = m[0]; // Drive reset of held state
                default: hit = 1'b0;
            endcase
            bresp_d = hit ? 2'b00 : 2'b10;
        end
        else if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
        end
        if (rd_fire)
        begin
            rvalid_d = 1'b1;
            rresp_d = 2'b00;
            unique case (s_axi_araddr)
                `OCD_OFS_OC_LEVEL: rdata_d = {24'h0, oc_level_q};
                `OCD_OFS_OC_DELAY: rdata_d = {18'h0, oc_delay_q};
                `OCD_OFS_ZC_LEVEL: rdata_d = {24'h0, zc_level_q};
                `OCD_OFS_ZC_TIME: rdata_d = {18'h0, zc_time_q};
                `OCD_OFS_OC_RETAIN: rdata_d = {18'h0, oc_retain_q};
                `OCD_OFS_OC_ACTION: rdata_d = {31'h0, action_q};
                `OCD_OFS_TERM_A: rdata_d = {24'h0, term_a_q};
                `OCD_OFS_TERM_B: rdata_d = {24'h0, term_b_q};
                `OCD_OFS_STATUS: rdata_d = {16'h0,
                    (fault_q ? `OCD_FAULT_CODE : 8'h00),
                    4'h0, samp_act_q, fault_q, zc_flag_q, oc_flag};
                `OCD_OFS_IRQ_STAT: rdata_d = {29'h0, irq_stat_q};
                `OCD_OFS_IRQ_MASK: rdata_d = {29'h0, irq_mask_q};
                `OCD_OFS_CTRL: rdata_d = 32'h0000_0000;
                default:
                begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = 2'b10;
                end
            endcase
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
        end
    end

    // ==========================================================
    // Time base and sampling
    // Detectors look at a sample refreshed every 100 ms, which sets
    // the response latency; a faster sample would chatter the brake relay
    assign tick = (tick_cnt_q == 20'(TICK_CYCLES - 1));
    // Auto-tuning counts as running for both detectors
    assign active = samp_act_q;
    assign above = active && (samp_q > oc_level_q);
    assign below = active && (zc_level_q != 8'h00)
        && (samp_q < zc_level_q);

    always_comb
    begin
        tick_cnt_d = tick ? 20'h00000 : tick_cnt_q + 20'h00001;
        resp_cnt_d = resp_cnt_q;
        samp_d = samp_q;
        samp_act_d = samp_act_q;
        if (tick)
        begin
            if (resp_cnt_q == 4'(`OCD_RESP_TICKS - 1))
            begin
                resp_cnt_d = 4'h0;
                samp_d = current_pct;
                samp_act_d = running || tuning;
            end
            else
            begin
                resp_cnt_d = resp_cnt_q + 4'h1;
            end
        end
    end

    // ==========================================================
    // Overcurrent detector
    always_comb
    begin
        oc_cnt_d = oc_cnt_q;
        oc_ret_d = oc_ret_q;
        oc_st_d = oc_st_q;
        act_eff_d = act_eff_q;
        fault_d = fault_q;
        oc_ev = 3'b000;
        // Selector is taken over only while the flag is off
        if (oc_st_q == OC_OFF)
        begin
            act_eff_d = action_q;
        end
        if (!above)
        begin
            oc_cnt_d = 14'h0000;
        end
        // Drive reset goes first, so a trip in the same cycle still wins
        if (fault_clr)
        begin
            fault_d = 1'b0;
            oc_st_d = OC_OFF;
            oc_cnt_d = 14'h0000;
        end
        unique case (oc_st_q)
            OC_OFF:
            begin
                if (tick && above)
                begin
                    if (oc_cnt_q >= oc_delay_q)
                    begin
                        oc_cnt_d = 14'h0000;
                        oc_ret_d = oc_retain_q;
                        oc_ev[`OCD_BIT_OC] = 1'b1;
                        if (act_eff_q)
                        begin
                            fault_d = 1'b1;
                            oc_ev[`OCD_BIT_FAULT] = 1'b1;
                        end
                        if (oc_retain_q == `OCD_RETAIN_HOLD)
                        begin
                            oc_st_d = act_eff_q ? OC_TO_RESET : OC_TO_START;
                        end
                        else
                        begin
                            oc_st_d = OC_TIMED;
                        end
                    end
                    else
                    begin
                        oc_cnt_d = oc_cnt_q + 14'h0001;
                    end
                end
            end
            OC_TIMED:
            begin
                if (oc_ret_q == 14'h0000)
                begin
                    oc_st_d = OC_OFF;
                end
                else if (tick)
                begin
                    oc_ret_d = oc_ret_q - 14'h0001;
                end
            end
            OC_TO_START:
            begin
                if (start_cmd)
                begin
                    oc_st_d = OC_OFF;
                end
            end
            OC_TO_RESET:
            begin
                if (fault_clr)
                begin
                    oc_st_d = OC_OFF;
                end
            end
        endcase
    end

    // ==========================================================
    // Zero-current detector and terminals
    always_comb
    begin
        zc_cnt_d = zc_cnt_q;
        zc_min_d = zc_min_q;
        zc_flag_d = zc_flag_q;
        if (!below)
        begin
            zc_cnt_d = 14'h0000;
        end
        if (tick)
        begin
            if (!zc_flag_q && below)
            begin
                if (zc_cnt_q >= zc_time_q)
                begin
                    zc_flag_d = 1'b1;
                    zc_min_d = 4'(`OCD_ZC_MIN_TICKS);
                end
                else
                begin
                    zc_cnt_d = zc_cnt_q + 14'h0001;
                end
            end
            else if (zc_flag_q)
            begin
                if (zc_min_q != 4'h0)
                begin
                    zc_min_d = zc_min_q - 4'h1;
                end
                else if (!below)
                begin
                    zc_flag_d = 1'b0;
                end
            end
        end
        // Rising edge of the flag feeds the sticky event bit
        zc_rise = zc_flag_d && !zc_flag_q;
        term_a_o_d = term_out(term_a_q, oc_flag, zc_flag_q);
        term_b_o_d = term_out(term_b_q, oc_flag, zc_flag_q);
    end

    assign terminal_a = term_a_o_q;
    assign terminal_b = term_b_o_q;
    assign trip = fault_q;
    // Events of both detectors, one driver per bit
    assign events = oc_ev | {1'b0, zc_rise, 1'b0};
    assign irq = |(irq_stat_q & irq_mask_q);

    // ==========================================================
    // State registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            oc_level_q <= `OCD_RST_OC_LEVEL;
            oc_delay_q <= `OCD_RST_OC_DELAY;
            zc_level_q <= `OCD_RST_ZC_LEVEL;
            zc_time_q <= `OCD_RST_ZC_TIME;
            oc_retain_q <= `OCD_RST_OC_RETAIN;
            action_q <= 1'b0;
            term_a_q <= `OCD_RST_TERM;
            term_b_q <= `OCD_RST_TERM;
            irq_stat_q <= 3'h0;
            irq_mask_q <= 3'h0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            rvalid_q <= 1'b0;
            rresp_q <= 2'b00;
            rdata_q <= 32'h0000_0000;
            tick_cnt_q <= 20'h00000;
            resp_cnt_q <= 4'h0;
            samp_q <= 8'h00;
            samp_act_q <= 1'b0;
            oc_cnt_q <= 14'h0000;
            oc_ret_q <= 14'h0000;
            oc_st_q <= OC_OFF;
            act_eff_q <= 1'b0;
            fault_q <= 1'b0;
            zc_cnt_q <= 14'h0000;
            zc_min_q <= 4'h0;
            zc_flag_q <= 1'b0;
            term_a_o_q <= 1'b0;
            term_b_o_q <= 1'b0;
        end
        else
        begin
            oc_level_q <= oc_level_d;
            oc_delay_q <= oc_delay_d;
            zc_level_q <= zc_level_d;
            zc_time_q <= zc_time_d;
            oc_retain_q <= oc_retain_d;
            action_q <= action_d;
            term_a_q <= term_a_d;
            term_b_q <= term_b_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            tick_cnt_q <= tick_cnt_d;
            resp_cnt_q <= resp_cnt_d;
            samp_q <= samp_d;
            samp_act_q <= samp_act_d;
            oc_cnt_q <= oc_cnt_d;
            oc_ret_q <= oc_ret_d;
            oc_st_q <= oc_st_d;
            act_eff_q <= act_eff_d;
            fault_q <= fault_d;
            zc_cnt_q <= zc_cnt_d;
            zc_min_q <= zc_min_d;
            zc_flag_q <= zc_flag_d;
            term_a_o_q <= term_a_o_d;
            term_b_o_q <= term_b_o_d;
        end
    end
endmodule

// >>> tb/ocd_asserts.sv
// Purpose: Port checks of the current detector
// Assumes: Bound onto ocd_top, one clock domain
// Notes: Bus latencies are the designer's
`timescale 1ns/10ps
module ocd_asserts (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_arvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Detector outputs
    input wire logic terminal_a,
    input wire logic terminal_b,
    input wire logic trip,
    input wire logic irq
);
    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    r_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
        else $error("read answer without request");
    w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    b_late_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    r_next_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    reset_quiet_a: assert property ($rose(aresetn) |->
        !trip && !irq && !terminal_a && !terminal_b) else $error("outputs not reset");
    trip_sticky_a: assert property ($fell(trip) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("fault cleared without reset write");
endmodule
bind ocd_top ocd_asserts i_ocd_asserts (.*);

// >>> tb/ocd_brake_model.sv
// Purpose: Mechanical brake driven by the zero-current terminal
// Assumes: Terminal set to the inverted zero-current code
// Notes: Brake closes while the terminal is low
`timescale 1ns/10ps
module ocd_brake_model (
    // Clock
    input wire logic aclk,
    // Terminal from the detector
    input wire logic terminal,
    // Brake state
    output logic brake_closed_q
);
    // ==========================================================
    // Contactor follows the terminal one cycle late
    always_ff @(posedge aclk)
    begin
        brake_closed_q <= !terminal;
    end
endmodule

// >>> tb/tb_top.sv
// Purpose: Register and terminal tests of the current detector
// Assumes: Tick shortened to four cycles
// Notes: Every wait is bounded
`timescale 1ns/10ps
module tb_top;
    // ==========================================================
    // Bench signals
    // Answer readies stay high, so no answer is ever stalled
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 1, arv = 0, rr = 1;
    logic run = 0, tun = 0, st = 0;
    logic [7:0] awa = 0, ara = 0, cur = 0;
    logic [31:0] wdt = 0;
    logic awrdy, wrdy, bvld, arrdy, rvld, ta, tb_, trp, irq, brk;
    logic [31:0] rdat;
    logic [1:0] rrsp, brsp;
    logic [4:0] pins;
    int err_total = 0, n_checks = 0;
    assign pins = {brk, irq, trp, tb_, ta};
    always #10 aclk = ~aclk;
    // ==========================================================
    // Design and brake
    ocd_top #(.TICK_CYCLES(4)) i_ocd_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
        .s_axi_wdata(wdt), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(brsp), .s_axi_bvalid(bvld), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
        .s_axi_rdata(rdat), .s_axi_rresp(rrsp), .s_axi_rvalid(rvld), .s_axi_rready(rr),
        .current_pct(cur), .running(run), .tuning(tun), .start_cmd(st),
        .terminal_a(ta), .terminal_b(tb_), .trip(trp), .irq(irq)
    );
    ocd_brake_model i_ocd_brake_model (.aclk(aclk), .terminal(tb_), .brake_closed_q(brk));
    // ==========================================================
    // Verdict, compare and bounded waits
    task automatic tally_and_finish();
        if (err_total == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic to_chk(input int n);
        if (n >= 3999)
        begin
            err_total++;
            tally_and_finish();
        end
    endtask
    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic pa, pw;
        n = 0;
        pa = 1;
        pw = 1;
        awa <= a;
        wdt <= d;
        awv <= 1;
        wv <= 1;
        while ((pa || pw) && n < 3999)
        begin
            @(posedge aclk);
            n++;
            if (pa && awrdy)
            begin
                awv <= 0;
                pa = 0;
            end
            if (pw && wrdy)
            begin
                wv <= 0;
                pw = 0;
            end
        end
        while (!bvld && n < 3999)
        begin
            @(posedge aclk);
            n++;
        end
        to_chk(n);
        chk(brsp, 2'h0);
    endtask
    // Read with data and response compared
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        ara <= a;
        arv <= 1;
        do
        begin
            @(posedge aclk);
            n++;
        end while (!arrdy && n < 3999);
        arv <= 0;
        while (!rvld && n < 3999)
        begin
            @(posedge aclk);
            n++;
        end
        to_chk(n);
        chk(rdat, e);
        chk(rrsp, er);
    endtask
    task automatic wait_pin(input int s, input logic v);
        int n;
        n = 0;
        while (pins[s] !== v && n < 3999)
        begin
            @(posedge aclk);
            n++;
        end
        to_chk(n);
        chk(pins[s], v);
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(8'h00, 32'h96, 2'h0);
        rd(8'h08, 32'h5, 2'h0);
        rd(8'h0c, 32'h32, 2'h0);
        rd(8'h10, 32'ha, 2'h0);
        rd(8'h30, 32'h0, 2'h2);
        wr(8'h18, 32'h0c);
        wr(8'h1c, 32'h71);
        wr(8'h28, 32'h7);
        wr(8'h04, 32'h32);
        run <= 1;
        cur <= 8'h3c;
        wait_pin(1, 1);
        // Overcurrent broken off inside the delay, then held
        cur <= 8'h97;
        repeat (120) @(posedge aclk);
        cur <= 8'h96;
        repeat (80) @(posedge aclk);
        cur <= 8'h97;
        repeat (120) @(posedge aclk);
        chk(ta, 0);
        wait_pin(0, 1);
        chk(trp, 0);
        chk(irq, 1);
        cur <= 8'h96;
        repeat (20) @(posedge aclk);
        chk(ta, 1);
        wait_pin(0, 0);
        wr(8'h24, 32'h7);
        chk(irq, 0);
        // Zero current on the inverted terminal and the brake
        cur <= 8'h04;
        wait_pin(1, 0);
        wait_pin(4, 1);
        cur <= 8'h3c;
        repeat (20) @(posedge aclk);
        chk(tb_, 0);
        wait_pin(1, 1);
        wr(8'h08, 32'h0);
        cur <= 8'h00;
        repeat (600) @(posedge aclk);
        chk(tb_, 1);
        // Trip during auto-tuning, cleared by drive reset
        wr(8'h04, 32'h0);
        wr(8'h14, 32'h1);
        run <= 0;
        tun <= 1;
        cur <= 8'hc8;
        wait_pin(2, 1);
        rd(8'h20, 32'h10d, 2'h0);
        cur <= 8'h00;
        wait_pin(0, 0);
        chk(trp, 1);
        wr(8'h2c, 32'h1);
        wait_pin(2, 0);
        // Hold code until start, trip selected while flag on
        wr(8'h14, 32'h0);
        wr(8'h10, 32'h270f);
        cur <= 8'hc8;
        wait_pin(0, 1);
        cur <= 8'h00;
        repeat (200) @(posedge aclk);
        chk(ta, 1);
        wr(8'h14, 32'h1);
        chk(trp, 0);
        st <= 1;
        @(posedge aclk);
        st <= 0;
        wait_pin(0, 0);
        chk(trp, 0);
        // Opposite polarity codes on both terminals
        wr(8'h18, 32'h70);
        wait_pin(0, 1);
        wr(8'h1c, 32'hd);
        wait_pin(1, 0);
        tally_and_finish();
    end
endmodule
